// *** ddrcp_pkg.sv ***
package ddrcp_pkg;

  localparam int ROW_W = 13;
  localparam int BANK_W = 3;
  localparam int LCOL_W = 8;
  localparam int MCOL_W = 10;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 64;
  localparam int MASK_W = 8;
  localparam int SIZE_W = 2;
  localparam int COL_LSB = 0;
  localparam int BANK_LSB = 8;
  localparam int ROW_LSB = 11;
  localparam int COL_SHIFT = 2;
  localparam int QDEPTH = 4;
  localparam int QPTR_W = 2;
  localparam int QCNT_W = 3;
  localparam int PHY_RD_LAT = 2;
  localparam int ECC_LAT_MAX = 3;
  localparam logic [QCNT_W-1:0] QCNT_FULL = 3'h4;
  localparam logic [SIZE_W-1:0] SIZE_ONE = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_TWO = 2'h2;
  localparam logic [SIZE_W-1:0] SIZE_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 64'h0;
  localparam logic [MASK_W-1:0] MASK_RST = 8'h00;

  typedef enum logic [1:0] {
    DDRCP_CMD_NOP = 2'h0,
    DDRCP_CMD_WR = 2'h1,
    DDRCP_CMD_RD = 2'h2
  } ddrcp_cmd_t;

  typedef enum logic [1:0] {
    DDRCP_ST_IDLE = 2'h0,
    DDRCP_ST_WPRE = 2'h1,
    DDRCP_ST_WDAT = 2'h2,
    DDRCP_ST_RWIN = 2'h3
  } ddrcp_st_t;

  function automatic logic [ROW_W-1:0] ddrcp_row(input logic [ADDR_W-1:0] a);
    ddrcp_row = a[ROW_LSB +: ROW_W];
  endfunction

  function automatic logic [BANK_W-1:0] ddrcp_bank(input logic [ADDR_W-1:0] a);
    ddrcp_bank = a[BANK_LSB +: BANK_W];
  endfunction

  // half-rate: each local word is four memory beats wide
  function automatic logic [MCOL_W-1:0] ddrcp_col(input logic [ADDR_W-1:0] a);
    ddrcp_col = {a[COL_LSB +: LCOL_W], 2'h0};
  endfunction

endpackage

// *** ddrcp_if.sv ***
`timescale 1ns/1ps
interface ddrcp_if;
  logic wr_req;
  logic rd_req;
  logic [ddrcp_pkg::SIZE_W-1:0] size;
  logic [ddrcp_pkg::ADDR_W-1:0] addr;
  logic [ddrcp_pkg::DATA_W-1:0] wdata;
  logic [ddrcp_pkg::MASK_W-1:0] be;
  logic ready;
  logic [ddrcp_pkg::DATA_W-1:0] rdata;
  logic rdata_valid;
  ddrcp_pkg::ddrcp_cmd_t phy_cmd;
  logic [ddrcp_pkg::ROW_W-1:0] phy_row;
  logic [ddrcp_pkg::BANK_W-1:0] phy_bank;
  logic [ddrcp_pkg::MCOL_W-1:0] phy_col;
  logic [ddrcp_pkg::DATA_W-1:0] phy_wdata;
  logic [ddrcp_pkg::MASK_W-1:0] phy_dm;
  logic phy_wdata_valid;
  logic phy_dqs_burst;
  logic phy_doing_rd;
  logic [ddrcp_pkg::DATA_W-1:0] phy_rdata;
  logic phy_rdata_valid;

  modport ctl (
    input wr_req, rd_req, size, addr, wdata, be, phy_rdata, phy_rdata_valid,
    output ready, rdata, rdata_valid, phy_cmd, phy_row, phy_bank, phy_col,
    output phy_wdata, phy_dm, phy_wdata_valid, phy_dqs_burst, phy_doing_rd
  );

  modport far (
    output wr_req, rd_req, size, addr, wdata, be, phy_rdata, phy_rdata_valid,
    input ready, rdata, rdata_valid, phy_cmd, phy_row, phy_bank, phy_col,
    input phy_wdata, phy_dm, phy_wdata_valid, phy_dqs_burst, phy_doing_rd
  );
endinterface

// *** ddrcp_ctrl.sv ***
// Contract
// R1: user write gives request, size, address together
// R2: memory column is local column shifted two
// R3: accept until command queue full, then drop ready
// R4: user may read back written address, size one
// R5: drive command and address for each request
// R6: write valid exactly with write data, masks
// R7: strobe burst frames each write burst
// R8: read window high one cycle per beat
// R9: phy captures only while read window high
// R10: phy flags each valid resynchronised read word
// R11: user read valid marks each read word
// R12: no added read delay without correction logic
// R13: correction adds one or three cycles
// R14: user holds request until ready seen high
// R15: size two write takes two accepted cycles
// R16: read data returns in request order
`timescale 1ns/1ps
module ddrcp_ctrl #(
  parameter int ECC_LAT = 0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  ddrcp_if.ctl bus
);

  ////////////////////////////////////////////////////////////////////////////
  // command queue
  logic q_wr_r [ddrcp_pkg::QDEPTH];
  logic [ddrcp_pkg::ADDR_W-1:0] q_addr_r [ddrcp_pkg::QDEPTH];
  logic [ddrcp_pkg::SIZE_W-1:0] q_size_r [ddrcp_pkg::QDEPTH];
  logic [ddrcp_pkg::DATA_W-1:0] q_d0_r [ddrcp_pkg::QDEPTH];
  logic [ddrcp_pkg::DATA_W-1:0] q_d1_r [ddrcp_pkg::QDEPTH];
  logic [ddrcp_pkg::MASK_W-1:0] q_m0_r [ddrcp_pkg::QDEPTH];
  logic [ddrcp_pkg::MASK_W-1:0] q_m1_r [ddrcp_pkg::QDEPTH];
  logic [ddrcp_pkg::QPTR_W-1:0] wptr_r;
  logic [ddrcp_pkg::QPTR_W-1:0] rptr_r;
  logic [ddrcp_pkg::QPTR_W-1:0] last_r;
  logic [ddrcp_pkg::QCNT_W-1:0] cnt_r;
  logic [ddrcp_pkg::QCNT_W-1:0] cnt_nxt;
  logic beat2_r;
  logic beat2_nxt;
  logic ready_r;
  logic push;
  logic push_b2;
  logic pop;

  ddrcp_pkg::ddrcp_st_t st_r;
  logic [ddrcp_pkg::SIZE_W-1:0] left_r;
  logic cur_two_r;
  logic [ddrcp_pkg::DATA_W-1:0] cur_d1_r;
  logic [ddrcp_pkg::MASK_W-1:0] cur_m1_r;

  // a new request only in a free slot, never during the second write beat
  assign push = ready_r && !beat2_r && (bus.wr_req || bus.rd_req); // [R3]
  assign push_b2 = beat2_r && bus.wr_req; // [R15]
  // the head is not issued while its second write word is still outstanding
  assign pop = (st_r == ddrcp_pkg::DDRCP_ST_IDLE) && (cnt_r != '0) &&
               !(beat2_r && (cnt_r == 3'h1));

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 3'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 3'h1;
    end
    beat2_nxt = beat2_r;
    if (push && bus.wr_req && (bus.size == ddrcp_pkg::SIZE_TWO)) begin
      beat2_nxt = 1'b1;
    end else if (push_b2) begin
      beat2_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      wptr_r <= '0;
      rptr_r <= '0;
      last_r <= '0;
      beat2_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      beat2_r <= beat2_nxt;
      // ready stays up for the second beat even when the queue just filled
      ready_r <= (cnt_nxt != ddrcp_pkg::QCNT_FULL) || beat2_nxt; // [R3] [R15]
      if (push) begin
        wptr_r <= wptr_r + 2'h1;
        last_r <= wptr_r;
      end
      if (pop) begin
        rptr_r <= rptr_r + 2'h1;
      end
    end
  end

  // queue storage has no reset; only the pointers give it meaning
  always_ff @(posedge ref_clk) begin
    if (push) begin
      q_wr_r[wptr_r] <= bus.wr_req; // [R1]
      q_addr_r[wptr_r] <= bus.addr;
      q_size_r[wptr_r] <= bus.size;
      q_d0_r[wptr_r] <= bus.wdata;
      q_m0_r[wptr_r] <= bus.be;
    end
    if (push_b2) begin
      q_d1_r[last_r] <= bus.wdata;
      q_m1_r[last_r] <= bus.be;
    end
  end

  assign bus.ready = ready_r;

  ////////////////////////////////////////////////////////////////////////////
  // issue towards the phy
  logic [1:0] cmd_r;
  logic [ddrcp_pkg::ROW_W-1:0] row_r;
  logic [ddrcp_pkg::BANK_W-1:0] bank_r;
  logic [ddrcp_pkg::MCOL_W-1:0] col_r;
  logic [ddrcp_pkg::DATA_W-1:0] wdat_r;
  logic [ddrcp_pkg::MASK_W-1:0] dm_r;
  logic wval_r;
  logic dqs_r;
  logic rwin_r;
  logic [ddrcp_pkg::DATA_W-1:0] cur_d0_r;
  logic [ddrcp_pkg::MASK_W-1:0] cur_m0_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ddrcp_pkg::DDRCP_ST_IDLE;
      cmd_r <= ddrcp_pkg::DDRCP_CMD_NOP;
      row_r <= '0;
      bank_r <= '0;
      col_r <= '0;
      left_r <= ddrcp_pkg::SIZE_RST;
      cur_two_r <= 1'b0;
      cur_d0_r <= ddrcp_pkg::DATA_RST;
      cur_d1_r <= ddrcp_pkg::DATA_RST;
      cur_m0_r <= ddrcp_pkg::MASK_RST;
      cur_m1_r <= ddrcp_pkg::MASK_RST;
      wdat_r <= ddrcp_pkg::DATA_RST;
      dm_r <= ddrcp_pkg::MASK_RST;
      wval_r <= 1'b0;
      dqs_r <= 1'b0;
      rwin_r <= 1'b0;
    end else begin
      cmd_r <= ddrcp_pkg::DDRCP_CMD_NOP;
      wval_r <= 1'b0;
      dqs_r <= 1'b0;
      rwin_r <= 1'b0;
      case (st_r)
        ddrcp_pkg::DDRCP_ST_IDLE: begin
          if (pop) begin
            cmd_r <= q_wr_r[rptr_r] ? ddrcp_pkg::DDRCP_CMD_WR
                                    : ddrcp_pkg::DDRCP_CMD_RD; // [R5]
            row_r <= ddrcp_pkg::ddrcp_row(q_addr_r[rptr_r]); // [R2]
            bank_r <= ddrcp_pkg::ddrcp_bank(q_addr_r[rptr_r]); // [R2]
            col_r <= ddrcp_pkg::ddrcp_col(q_addr_r[rptr_r]); // [R2]
            left_r <= q_size_r[rptr_r];
            cur_two_r <= (q_size_r[rptr_r] == ddrcp_pkg::SIZE_TWO);
            cur_d0_r <= q_d0_r[rptr_r];
            cur_d1_r <= q_d1_r[rptr_r];
            cur_m0_r <= q_m0_r[rptr_r];
            cur_m1_r <= q_m1_r[rptr_r];
            st_r <= q_wr_r[rptr_r] ? ddrcp_pkg::DDRCP_ST_WPRE : ddrcp_pkg::DDRCP_ST_RWIN;
          end
        end
        ddrcp_pkg::DDRCP_ST_WPRE: begin
          // strobe preamble one cycle ahead of the first word
          dqs_r <= 1'b1; // [R7]
          st_r <= ddrcp_pkg::DDRCP_ST_WDAT;
        end
        ddrcp_pkg::DDRCP_ST_WDAT: begin
          dqs_r <= 1'b1; // [R7]
          wval_r <= 1'b1; // [R6]
          wdat_r <= (cur_two_r && left_r == ddrcp_pkg::SIZE_ONE) ? cur_d1_r : cur_d0_r;
          dm_r <= (cur_two_r && left_r == ddrcp_pkg::SIZE_ONE) ? cur_m1_r : cur_m0_r;
          left_r <= left_r - 2'h1;
          if (left_r <= ddrcp_pkg::SIZE_ONE) begin
            st_r <= ddrcp_pkg::DDRCP_ST_IDLE;
          end
        end
        ddrcp_pkg::DDRCP_ST_RWIN: begin
          rwin_r <= 1'b1; // [R8]
          left_r <= left_r - 2'h1;
          if (left_r <= ddrcp_pkg::SIZE_ONE) begin
            st_r <= ddrcp_pkg::DDRCP_ST_IDLE;
          end
        end
        default: begin
          st_r <= ddrcp_pkg::DDRCP_ST_IDLE;
        end
      endcase
    end
  end

  assign bus.phy_cmd = ddrcp_pkg::ddrcp_cmd_t'(cmd_r);
  assign bus.phy_row = row_r;
  assign bus.phy_bank = bank_r;
  assign bus.phy_col = col_r;
  assign bus.phy_wdata = wdat_r;
  assign bus.phy_dm = dm_r;
  assign bus.phy_wdata_valid = wval_r; // [R6]
  assign bus.phy_dqs_burst = dqs_r; // [R7]
  assign bus.phy_doing_rd = rwin_r; // [R8]

  ////////////////////////////////////////////////////////////////////////////
  // read return; one in-order pipe keeps words in request order
  logic pv_r [ddrcp_pkg::ECC_LAT_MAX];
  logic [ddrcp_pkg::DATA_W-1:0] pd_r [ddrcp_pkg::ECC_LAT_MAX];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ddrcp_pkg::ECC_LAT_MAX; i++) begin
        pv_r[i] <= 1'b0;
        pd_r[i] <= ddrcp_pkg::DATA_RST;
      end
    end else begin
      pv_r[0] <= bus.phy_rdata_valid; // [R13]
      pd_r[0] <= bus.phy_rdata;
      for (int i = 1; i < ddrcp_pkg::ECC_LAT_MAX; i++) begin
        pv_r[i] <= pv_r[i-1];
        pd_r[i] <= pd_r[i-1];
      end
    end
  end

  // zero latency cannot come from a flop; this path is combinational by need
  generate
    if (ECC_LAT == 0) begin : g_noecc
      assign bus.rdata_valid = bus.phy_rdata_valid; // [R12] [R11] [R16]
      assign bus.rdata = bus.phy_rdata; // [R12]
    end else begin : g_ecc
      assign bus.rdata_valid = pv_r[ECC_LAT-1]; // [R13] [R11] [R16]
      assign bus.rdata = pd_r[ECC_LAT-1]; // [R13]
    end
  endgenerate

endmodule

// *** ddrcp_far.sv ***
`timescale 1ns/1ps
module ddrcp_far (
  input wire logic ref_clk,
  input wire logic rst_n,
  ddrcp_if.far bus,
  input wire logic usr_wr_go,
  input wire logic usr_rd_go,
  input wire logic [ddrcp_pkg::SIZE_W-1:0] usr_size,
  input wire logic [ddrcp_pkg::ADDR_W-1:0] usr_addr,
  input wire logic [ddrcp_pkg::DATA_W-1:0] usr_wdata0,
  input wire logic [ddrcp_pkg::DATA_W-1:0] usr_wdata1,
  input wire logic [ddrcp_pkg::MASK_W-1:0] usr_be,
  output logic usr_busy,
  output logic usr_rvalid,
  output logic [ddrcp_pkg::DATA_W-1:0] usr_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // user request side
  logic wr_r;
  logic rd_r;
  logic b2_r;
  logic [ddrcp_pkg::SIZE_W-1:0] size_r;
  logic [ddrcp_pkg::ADDR_W-1:0] addr_r;
  logic [ddrcp_pkg::DATA_W-1:0] d0_r;
  logic [ddrcp_pkg::DATA_W-1:0] d1_r;
  logic [ddrcp_pkg::MASK_W-1:0] be_r;
  logic taken;

  assign taken = (wr_r || rd_r) && bus.ready;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      b2_r <= 1'b0;
      size_r <= ddrcp_pkg::SIZE_RST;
      addr_r <= ddrcp_pkg::ADDR_RST;
      d0_r <= ddrcp_pkg::DATA_RST;
      d1_r <= ddrcp_pkg::DATA_RST;
      be_r <= ddrcp_pkg::MASK_RST;
      usr_busy <= 1'b0;
    end else if (!(wr_r || rd_r)) begin
      if (usr_wr_go || usr_rd_go) begin
        wr_r <= usr_wr_go; // [R1]
        rd_r <= !usr_wr_go && usr_rd_go;
        size_r <= usr_size;
        addr_r <= usr_addr;
        d0_r <= usr_wdata0;
        d1_r <= usr_wdata1;
        be_r <= usr_be;
        b2_r <= 1'b0;
        usr_busy <= 1'b1;
      end
    end else if (taken) begin
      // second write word stays up for one more accepted cycle
      if (wr_r && !b2_r && size_r == ddrcp_pkg::SIZE_TWO) begin
        b2_r <= 1'b1; // [R15]
      end else begin
        wr_r <= 1'b0;
        rd_r <= 1'b0;
        b2_r <= 1'b0;
        usr_busy <= 1'b0;
      end
    end
  end

  // everything holds until ready is seen high
  assign bus.wr_req = wr_r; // [R14]
  assign bus.rd_req = rd_r; // [R14] [R4]
  assign bus.size = size_r;
  assign bus.addr = addr_r;
  assign bus.wdata = b2_r ? d1_r : d0_r;
  assign bus.be = be_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      usr_rvalid <= 1'b0;
      usr_rdata <= ddrcp_pkg::DATA_RST;
    end else begin
      usr_rvalid <= bus.rdata_valid;
      usr_rdata <= bus.rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // physical side: small loop-back store indexed by low column bits
  logic [ddrcp_pkg::DATA_W-1:0] mem_r [16];
  logic [3:0] wadr_r;
  logic [3:0] radr_r;
  logic cv_r [ddrcp_pkg::PHY_RD_LAT];
  logic [ddrcp_pkg::DATA_W-1:0] cd_r [ddrcp_pkg::PHY_RD_LAT];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wadr_r <= 4'h0;
      radr_r <= 4'h0;
    end else begin
      if (bus.phy_cmd == ddrcp_pkg::DDRCP_CMD_WR) begin
        wadr_r <= bus.phy_col[5:2];
      end else if (bus.phy_wdata_valid) begin
        wadr_r <= wadr_r + 4'h1;
      end
      if (bus.phy_cmd == ddrcp_pkg::DDRCP_CMD_RD) begin
        radr_r <= bus.phy_col[5:2];
      end else if (bus.phy_doing_rd) begin
        radr_r <= radr_r + 4'h1;
      end
    end
  end

  // byte masks are ignored by this store; writes take whole words
  always_ff @(posedge ref_clk) begin
    if (bus.phy_wdata_valid) begin
      mem_r[wadr_r] <= bus.phy_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ddrcp_pkg::PHY_RD_LAT; i++) begin
        cv_r[i] <= 1'b0;
        cd_r[i] <= ddrcp_pkg::DATA_RST;
      end
    end else begin
      cv_r[0] <= bus.phy_doing_rd; // [R9]
      cd_r[0] <= bus.phy_doing_rd ? mem_r[radr_r] : ddrcp_pkg::DATA_RST; // [R9]
      for (int i = 1; i < ddrcp_pkg::PHY_RD_LAT; i++) begin
        cv_r[i] <= cv_r[i-1];
        cd_r[i] <= cd_r[i-1];
      end
    end
  end

  assign bus.phy_rdata_valid = cv_r[ddrcp_pkg::PHY_RD_LAT-1]; // [R10]
  assign bus.phy_rdata = cd_r[ddrcp_pkg::PHY_RD_LAT-1]; // [R10]

endmodule

// *** ddrcp_path_monitor.sv ***
`timescale 1ns/1ps
module ddrcp_path_monitor #(
  parameter int ECC_LAT = 0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_req,
  input wire logic rd_req,
  input wire logic [ddrcp_pkg::SIZE_W-1:0] size,
  input wire logic [ddrcp_pkg::ADDR_W-1:0] addr,
  input wire logic ready,
  input wire logic [ddrcp_pkg::DATA_W-1:0] rdata,
  input wire logic rdata_valid,
  input wire logic [1:0] phy_cmd,
  input wire logic [ddrcp_pkg::MCOL_W-1:0] phy_col,
  input wire logic phy_wdata_valid,
  input wire logic phy_dqs_burst,
  input wire logic phy_doing_rd,
  input wire logic [ddrcp_pkg::DATA_W-1:0] phy_rdata,
  input wire logic phy_rdata_valid
);
  localparam int RD_LAT = ddrcp_pkg::PHY_RD_LAT;
  logic beat2_r;
  logic take;
  logic [ddrcp_pkg::QCNT_W:0] pend_r;
  logic [ddrcp_pkg::QCNT_W:0] occ;

  assign take = (wr_req || rd_req) && ready && !beat2_r;
  // a command on the phy pins left the queue one edge before pend_r notices
  assign occ = pend_r - 4'(phy_cmd != ddrcp_pkg::DDRCP_CMD_NOP);

  // second beat of a size-two write is data only, not a new request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      beat2_r <= 1'b0;
    end else if (beat2_r) begin
      beat2_r <= !ready;
    end else begin
      beat2_r <= take && wr_req && size == ddrcp_pkg::SIZE_TWO;
    end
  end

  // accepted but not yet issued; an upper bound on queue occupancy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_r + 4'(take) - 4'(phy_cmd != ddrcp_pkg::DDRCP_CMD_NOP);
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence wr_burst_s;
    phy_dqs_burst && !phy_wdata_valid ##1 phy_dqs_burst && phy_wdata_valid;
  endsequence

  sequence rd_return_s;
    ##RD_LAT phy_rdata_valid;
  endsequence

  queue_bound_a: assert property (pend_r <= 4'(ddrcp_pkg::QDEPTH))
    else $error("command queue overfilled");
  ready_full_a: assert property (
    occ == 4'(ddrcp_pkg::QDEPTH) && !beat2_r |-> !ready)
    else $error("ready high with queue full");
  ready_room_a: assert property (
    $past(rst_n) && occ != 4'(ddrcp_pkg::QDEPTH) |-> ready)
    else $error("ready low with room in queue");
  col_shift_a: assert property (
    phy_cmd != ddrcp_pkg::DDRCP_CMD_NOP |-> phy_col[1:0] == 2'h0)
    else $error("memory column not word aligned");
  cmd_pulse_a: assert property (
    phy_cmd != ddrcp_pkg::DDRCP_CMD_NOP |=> phy_cmd == ddrcp_pkg::DDRCP_CMD_NOP)
    else $error("command longer than one cycle");
  wr_burst_a: assert property (phy_cmd == ddrcp_pkg::DDRCP_CMD_WR |=> wr_burst_s)
    else $error("write burst framing wrong");
  wv_framed_a: assert property (phy_wdata_valid |-> phy_dqs_burst)
    else $error("write data outside strobe burst");
  rd_window_a: assert property (phy_cmd == ddrcp_pkg::DDRCP_CMD_RD |=> phy_doing_rd)
    else $error("read window missing after read");
  rd_return_a: assert property (phy_doing_rd |-> rd_return_s)
    else $error("read word not returned");
  rv_cause_a: assert property (phy_rdata_valid |-> $past(phy_doing_rd, RD_LAT))
    else $error("read word without read window");
  req_hold_a: assert property (
    (wr_req || rd_req) && !ready |=> $stable(wr_req) && $stable(rd_req) && $stable(addr))
    else $error("request changed before accept");
  beat_two_a: assert property (take && wr_req && size == ddrcp_pkg::SIZE_TWO |=> wr_req)
    else $error("second write beat missing");

  if (ECC_LAT == 0) begin : g_direct
    zero_delay_a: assert property (
      rdata_valid == phy_rdata_valid && (!phy_rdata_valid || rdata == phy_rdata))
      else $error("read data delayed or altered");
  end else begin : g_ecc
    ecc_delay_a: assert property (
      phy_rdata_valid |-> ##ECC_LAT rdata_valid && rdata == $past(phy_rdata, ECC_LAT))
      else $error("corrected read delay wrong");
  end
endmodule

// *** ddrcp_bench.sv ***
`timescale 1ns/1ps
module ddrcp_bench;
  localparam int ECC_LAT = 0;
  localparam int ECC_LAT_ALT = 3;
  typedef struct packed {
    ddrcp_pkg::ddrcp_cmd_t cmd;
    logic [ddrcp_pkg::ADDR_W-1:0] addr;
  } ddrcp_exp_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic usr_wr_go = 1'b0;
  logic usr_rd_go = 1'b0;
  logic [ddrcp_pkg::SIZE_W-1:0] usr_size = ddrcp_pkg::SIZE_ONE;
  logic [ddrcp_pkg::ADDR_W-1:0] usr_addr = ddrcp_pkg::ADDR_RST;
  logic [ddrcp_pkg::DATA_W-1:0] usr_wdata0 = ddrcp_pkg::DATA_RST;
  logic [ddrcp_pkg::DATA_W-1:0] usr_wdata1 = ddrcp_pkg::DATA_RST;
  logic [ddrcp_pkg::MASK_W-1:0] usr_be = ddrcp_pkg::MASK_RST;
  logic usr_busy;
  logic usr_rvalid;
  logic [ddrcp_pkg::DATA_W-1:0] usr_rdata;
  logic usr_rvalid_ecc;
  logic [ddrcp_pkg::DATA_W-1:0] usr_rdata_ecc;
  logic [ddrcp_pkg::DATA_W-1:0] mem [16];
  logic [ddrcp_pkg::DATA_W-1:0] data_q [$];
  ddrcp_exp_t cmd_q [$];
  logic [ddrcp_pkg::DATA_W-1:0] data_e_q [$];
  logic [ddrcp_pkg::MASK_W-1:0] mask_q [$];
  int full_seen = 0;
  int err_count = 0;
  int checks_done = 0;

  always #5 ref_clk = ~ref_clk;

  ddrcp_if i_ddrcp_if ();
  ddrcp_ctrl #(.ECC_LAT(ECC_LAT)) i_ddrcp_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .bus(i_ddrcp_if));
  ddrcp_far i_ddrcp_far (.ref_clk(ref_clk), .rst_n(rst_n), .bus(i_ddrcp_if),
    .usr_wr_go(usr_wr_go), .usr_rd_go(usr_rd_go), .usr_size(usr_size), .usr_addr(usr_addr),
    .usr_wdata0(usr_wdata0), .usr_wdata1(usr_wdata1), .usr_be(usr_be), .usr_busy(usr_busy),
    .usr_rvalid(usr_rvalid), .usr_rdata(usr_rdata));
  ddrcp_path_monitor #(.ECC_LAT(ECC_LAT)) i_ddrcp_path_monitor (.ref_clk(ref_clk),
    .rst_n(rst_n), .wr_req(i_ddrcp_if.wr_req), .rd_req(i_ddrcp_if.rd_req),
    .size(i_ddrcp_if.size), .addr(i_ddrcp_if.addr), .ready(i_ddrcp_if.ready),
    .rdata(i_ddrcp_if.rdata), .rdata_valid(i_ddrcp_if.rdata_valid),
    .phy_cmd(i_ddrcp_if.phy_cmd), .phy_col(i_ddrcp_if.phy_col),
    .phy_wdata_valid(i_ddrcp_if.phy_wdata_valid), .phy_dqs_burst(i_ddrcp_if.phy_dqs_burst),
    .phy_doing_rd(i_ddrcp_if.phy_doing_rd), .phy_rdata(i_ddrcp_if.phy_rdata),
    .phy_rdata_valid(i_ddrcp_if.phy_rdata_valid));
  // second pair with correction delay, fed the same requests
  ddrcp_if i_ddrcp_if_ecc ();
  ddrcp_ctrl #(.ECC_LAT(ECC_LAT_ALT)) i_ddrcp_ctrl_ecc (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus(i_ddrcp_if_ecc));
  ddrcp_far i_ddrcp_far_ecc (.ref_clk(ref_clk), .rst_n(rst_n), .bus(i_ddrcp_if_ecc),
    .usr_wr_go(usr_wr_go), .usr_rd_go(usr_rd_go), .usr_size(usr_size), .usr_addr(usr_addr),
    .usr_wdata0(usr_wdata0), .usr_wdata1(usr_wdata1), .usr_be(usr_be), .usr_busy(),
    .usr_rvalid(usr_rvalid_ecc), .usr_rdata(usr_rdata_ecc));

  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic fail_msg(input string msg);
    err_count++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic cmp_data(input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) fail_msg("read word differs");
  endtask

  task automatic cmp_cmd(input ddrcp_exp_t e);
    checks_done++;
    if (i_ddrcp_if.phy_cmd !== e.cmd || i_ddrcp_if.phy_col !== {e.addr[7:0], 2'h0} ||
        i_ddrcp_if.phy_bank !== e.addr[10:8] || i_ddrcp_if.phy_row !== e.addr[23:11]) begin
      fail_msg("memory command or address differs");
    end
  endtask

  task automatic cmp_mask(input logic [7:0] exp);
    checks_done++;
    if (i_ddrcp_if.phy_dm !== exp) fail_msg("write mask differs");
  endtask

  // store model follows the far end: one word per local address, low four bits
  task automatic issue(input logic wr, input logic [1:0] sz, input logic [23:0] a);
    logic [63:0] d0;
    logic [63:0] d1;
    logic [7:0] m;
    int n;
    int takes;
    d0 = {$urandom, $urandom};
    d1 = {$urandom, $urandom};
    m = 8'($urandom);
    takes = (wr && sz == ddrcp_pkg::SIZE_TWO) ? 2 : 1;
    usr_wr_go <= wr;
    usr_rd_go <= !wr;
    usr_size <= sz;
    usr_addr <= a;
    usr_wdata0 <= d0;
    usr_wdata1 <= d1;
    usr_be <= m;
    cmd_q.push_back('{cmd: wr ? ddrcp_pkg::DDRCP_CMD_WR : ddrcp_pkg::DDRCP_CMD_RD, addr: a});
    if (wr) begin
      mem[a[3:0]] = d0;
      mask_q.push_back(m);
      if (sz == ddrcp_pkg::SIZE_TWO) begin
        mem[a[3:0] + 4'h1] = d1;
        mask_q.push_back(m);
      end
    end else begin
      data_q.push_back(mem[a[3:0]]);
      data_e_q.push_back(mem[a[3:0]]);
      if (sz == ddrcp_pkg::SIZE_TWO) begin
        data_q.push_back(mem[a[3:0] + 4'h1]);
        data_e_q.push_back(mem[a[3:0] + 4'h1]);
      end
    end
    @(posedge ref_clk);
    usr_wr_go <= 1'b0;
    usr_rd_go <= 1'b0;
    // return on the last accepted beat so the next request follows at once;
    // waiting for busy to fall would leave a gap and the queue never fills
    n = 0;
    while (takes > 0 && n < 200) begin
      @(posedge ref_clk);
      n++;
      if ((i_ddrcp_if.wr_req | i_ddrcp_if.rd_req) === 1'b1 && i_ddrcp_if.ready === 1'b1) takes--;
    end
    if (takes > 0) begin
      fail_msg("request never accepted");
      end_sim();
    end
  endtask

  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (usr_rvalid === 1'b1) begin
      if (data_q.size() == 0) fail_msg("unexpected read word");
      else cmp_data(data_q.pop_front(), usr_rdata);
    end
    if (usr_rvalid_ecc === 1'b1) begin
      if (data_e_q.size() == 0) fail_msg("unexpected delayed read word");
      else cmp_data(data_e_q.pop_front(), usr_rdata_ecc);
    end
    if (i_ddrcp_if.phy_wdata_valid === 1'b1) begin
      if (mask_q.size() == 0) fail_msg("unexpected write word");
      else cmp_mask(mask_q.pop_front());
    end
    if (usr_busy === 1'b1 && i_ddrcp_if.ready === 1'b0) full_seen++;
    if (rst_n === 1'b1 && i_ddrcp_if.phy_cmd !== ddrcp_pkg::DDRCP_CMD_NOP) begin
      if (cmd_q.size() == 0) fail_msg("unexpected memory command");
      else cmp_cmd(cmd_q.pop_front());
    end
  end

  initial begin
    int n;
    logic [23:0] a;
    logic [1:0] sz;
    n = $urandom(32'h5eea);
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    // write, read back, write, read back, all size one and back to back
    issue(1'b1, ddrcp_pkg::SIZE_ONE, 24'h000002);
    issue(1'b0, ddrcp_pkg::SIZE_ONE, 24'h000002);
    issue(1'b1, ddrcp_pkg::SIZE_ONE, 24'h000004);
    issue(1'b0, ddrcp_pkg::SIZE_ONE, 24'h000004);
    // size-one writes arrive faster than they issue, so the queue fills
    for (int i = 0; i < 16; i++) begin
      issue(1'b1, ddrcp_pkg::SIZE_ONE, 24'($urandom));
    end
    // size-two writes fill every store word and push the queue toward full
    for (int i = 0; i < 8; i++) begin
      a = 24'($urandom);
      a[3:0] = 4'(2 * i);
      issue(1'b1, ddrcp_pkg::SIZE_TWO, a);
    end
    for (int i = 0; i < 40; i++) begin
      a = 24'($urandom);
      sz = ($urandom & 1) ? ddrcp_pkg::SIZE_TWO : ddrcp_pkg::SIZE_ONE;
      if (sz == ddrcp_pkg::SIZE_TWO) a[0] = 1'b0;
      issue(1'($urandom), sz, a);
    end
    n = 0;
    while ((data_q.size() != 0 || data_e_q.size() != 0 || cmd_q.size() != 0 ||
            mask_q.size() != 0) && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 1000) fail_msg("results missing at end");
    checks_done++;
    if (full_seen == 0) fail_msg("queue never filled");
    end_sim();
  end
endmodule
